/* File: rtl/ssp_pin_ctrl.v */
// Purpose: Pin-level control of the serial slave, multiplexed status output, interrupt pin,
//          bus power detection and general-purpose inputs.
// Assumes: All pins come from outside the clk domain; the serial clock is far slower than clk.
// Notes: The command protocol and register map live elsewhere; this block serves their pins.
`timescale 1ns/1ps
`include "ssp_regs.vh"

// Contract
// RL1: Drive output data pin only in full-duplex while selected; otherwise float it.
// RL2: Half-duplex uses the input pin bidirectionally; device drives it during read bytes.
// RL3: Status output shows operate, bus power, bus activity or SOF by two select bits.
// RL4: Edge interrupt mode drives the interrupt pin push-pull with selectable polarity.
// RL5: Level interrupt mode is open-drain, pulled low while an interrupt is asserted.
// RL6: Interrupt pin signals only once the interrupt pin enable bit is set.
// RL7: Report appearance and loss of bus power by events and a status bit.
// RL8: General input pin states read back in bits seven to four of I/O register.
// RL9: Writes to the general input bit positions are ignored.
// RL10: Internal timing derives from a 12 MHz reference.
// RL11: Slave select high deselects the interface and ignores serial clock edges.
// RL12: Sample input data on rising serial clock, change output on falling edge.
// RL13: Interrupt pin stays inactive while the enable bit is cleared.
module ssp_pin_ctrl #(
  parameter GPIN_W = 4
) (
  // Clock, reset, enable
  input wire clk,
  input wire rstn,
  input wire ce,

  // Serial link pins
  input wire sclk,
  input wire ss_n,
  input wire mosi_in,
  output reg mosi_out,
  output reg mosi_oe_n,
  output reg miso_out,
  output reg miso_oe_n,

  // Serial byte side
  input wire [7:0] tx_data,
  input wire hd_read_byte,
  output reg [7:0] rx_byte,
  output reg rx_valid,
  output reg tx_next,
  output reg selected,

  // Configuration
  input wire full_duplex,
  input wire status_select_high,
  input wire status_select_low,
  input wire interrupt_pin_enable,
  input wire int_level_mode,
  input wire int_pos_polarity,

  // Internal status sources
  input wire operate,
  input wire bus_activity,
  input wire sof_pulse,
  input wire irq_pending,

  // Status and interrupt pins
  output reg multiplexed_status_output,
  output reg int_out,
  output reg int_oe_n,

  // Bus power
  input wire bus_power_comparator_input,
  output reg bus_power_detect,
  output reg bus_power_on_event,
  output reg bus_power_off_event,

  // General-purpose inputs and I/O register
  input wire [GPIN_W-1:0] general_input,
  input wire io_wr,
  input wire [7:0] io_wr_data,
  output reg [7:0] io_rd_data,
  output reg [3:0] general_output,

  // Reference tick
  output reg ref_tick
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // The first stage is read only by the second; edges compare stages two and three.
  // Reset values match the idle pin levels, so no false edge or select follows reset.
  reg sclk_s1_r;
  reg sclk_s2_r;
  reg sclk_s3_r;
  reg ss_s1_r;
  reg ss_s2_r;
  reg ss_s3_r;
  reg mosi_s1_r;
  reg mosi_s2_r;
  reg vb_s1_r;
  reg vb_s2_r;
  reg [GPIN_W-1:0] gp_s1_r;
  reg [GPIN_W-1:0] gp_s2_r;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      ss_s1_r <= 1'b1;
      ss_s2_r <= 1'b1;
      ss_s3_r <= 1'b1;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
      vb_s1_r <= 1'b0;
      vb_s2_r <= 1'b0;
      gp_s1_r <= {GPIN_W{1'b1}};
      gp_s2_r <= {GPIN_W{1'b1}};
    end else if (ce) begin
      sclk_s1_r <= sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      ss_s1_r <= ss_n;
      ss_s2_r <= ss_s1_r;
      ss_s3_r <= ss_s2_r;
      mosi_s1_r <= mosi_in;
      mosi_s2_r <= mosi_s1_r;
      vb_s1_r <= bus_power_comparator_input;
      vb_s2_r <= vb_s1_r;
      gp_s1_r <= general_input;
      gp_s2_r <= gp_s1_r;
    end
  end

  wire active = ~ss_s2_r;
  wire ss_fall = ss_s3_r & ~ss_s2_r;
  wire sclk_rise = active & ~sclk_s3_r & sclk_s2_r; // RL11
  wire sclk_fall = active & sclk_s3_r & ~sclk_s2_r; // RL11

  // ****************************************
  // Serial shifter
  // ****************************************
  // A partial byte is dropped when select rises; the count restarts with the next frame.
  reg [`SSP_BIT_CNT_W-1:0] bit_cnt_r;
  reg [7:0] rx_sh_r;
  reg [7:0] tx_sh_r;
  reg hd_drive_r;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r <= {`SSP_BIT_CNT_W{1'b0}};
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
      tx_next <= 1'b0;
      hd_drive_r <= 1'b0;
    end else if (ce) begin
      rx_valid <= 1'b0;
      tx_next <= 1'b0;
      if (!active) begin
        bit_cnt_r <= {`SSP_BIT_CNT_W{1'b0}}; // RL11
        hd_drive_r <= 1'b0;
      end else if (ss_fall) begin
        bit_cnt_r <= {`SSP_BIT_CNT_W{1'b0}};
        tx_sh_r <= tx_data;
        hd_drive_r <= hd_read_byte;
      end else if (sclk_rise) begin
        rx_sh_r <= {rx_sh_r[6:0], mosi_s2_r}; // RL12
        bit_cnt_r <= bit_cnt_r + 1'b1;
        if (bit_cnt_r == `SSP_BIT_LAST) begin
          rx_byte <= {rx_sh_r[6:0], mosi_s2_r};
          rx_valid <= 1'b1;
          tx_next <= 1'b1;
        end
      end else if (sclk_fall) begin
        if (bit_cnt_r == {`SSP_BIT_CNT_W{1'b0}}) begin
          tx_sh_r <= tx_data; // RL12
          hd_drive_r <= hd_read_byte; // RL2
        end else begin
          tx_sh_r <= {tx_sh_r[6:0], 1'b0}; // RL12
        end
      end
    end
  end

  // ****************************************
  // Data pin drivers
  // ****************************************
  // Enables are active low: low means this block drives the pin.
  // Both data pins carry the same shifter bit; only the enables decide which one is driven.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      miso_out <= 1'b0;
      miso_oe_n <= 1'b1;
      mosi_out <= 1'b0;
      mosi_oe_n <= 1'b1;
      selected <= 1'b0;
    end else if (ce) begin
      selected <= active;
      miso_out <= tx_sh_r[7];
      miso_oe_n <= ~(full_duplex & active); // RL1
      mosi_out <= tx_sh_r[7];
      mosi_oe_n <= ~(~full_duplex & active & hd_drive_r); // RL2
    end
  end

  // ****************************************
  // Status mux and interrupt pin
  // ****************************************
  // The enable gate sits before the pin logic, so a pending event never leaks while disabled.
  wire irq_act = interrupt_pin_enable & irq_pending; // RL6 RL13
  reg mux_sel;

  always @* begin
    case ({status_select_high, status_select_low}) // RL3
      `SSP_SEL_OPERATE: mux_sel = operate;
      `SSP_SEL_BUS_POWER: mux_sel = bus_power_detect;
      `SSP_SEL_BUS_ACTIVITY: mux_sel = bus_activity;
      `SSP_SEL_SOF: mux_sel = sof_pulse;
      default: mux_sel = operate;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      multiplexed_status_output <= 1'b0;
      int_out <= 1'b0;
      int_oe_n <= 1'b1;
    end else if (ce) begin
      multiplexed_status_output <= mux_sel; // RL3
      // In level mode the pin is only ever pulled low or released, never driven high.
      if (int_level_mode) begin
        int_out <= 1'b0; // RL5
        int_oe_n <= ~irq_act; // RL5
      end else begin
        int_out <= int_pos_polarity ? irq_act : ~irq_act; // RL4
        int_oe_n <= 1'b0; // RL4
      end
    end
  end

  // ****************************************
  // Bus power detection
  // ****************************************
  // Events are one-cycle pulses; a sticky flag belongs to the register file that reads them.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_power_detect <= 1'b0;
      bus_power_on_event <= 1'b0;
      bus_power_off_event <= 1'b0;
    end else if (ce) begin
      bus_power_detect <= vb_s2_r; // RL7
      bus_power_on_event <= vb_s2_r & ~bus_power_detect; // RL7
      bus_power_off_event <= ~vb_s2_r & bus_power_detect; // RL7
    end
  end

  // ****************************************
  // I/O pin register
  // ****************************************
  // Only the output half is storage; the input half always mirrors the pins.
  // Write data is forwarded to the read half at once, so a read just after a write sees it.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      general_output <= 4'h0;
      io_rd_data <= `SSP_IO_RESET;
    end else if (ce) begin
      if (io_wr) begin
        general_output <= io_wr_data[`SSP_IO_GPOUT_MSB:`SSP_IO_GPOUT_LSB]; // RL9
      end
      io_rd_data[`SSP_IO_GPIN_MSB:`SSP_IO_GPIN_LSB] <= gp_s2_r[3:0]; // RL8
      io_rd_data[`SSP_IO_GPOUT_MSB:`SSP_IO_GPOUT_LSB] <= io_wr ?
        io_wr_data[`SSP_IO_GPOUT_MSB:`SSP_IO_GPOUT_LSB] : general_output;
    end
  end

  // ****************************************
  // Reference tick
  // ****************************************
  // A fractional accumulator gives an average 12 MHz tick; single ticks jitter by one clk.
  // ce also stalls the accumulator, so the rate is 12 ticks per 250 enabled cycles.
  reg [`SSP_ACC_W-1:0] acc_r;
  reg [`SSP_ACC_W-1:0] acc_nxt;
  reg tick_nxt;
  wire [`SSP_ACC_W-1:0] acc_sum = acc_r + `SSP_REF_MHZ;

  // The wrap test is on the sum, so the accumulator never holds a value at or above the wrap point.
  always @* begin
    acc_nxt = acc_sum;
    tick_nxt = 1'b0;
    if (acc_sum >= `SSP_CLK_MHZ) begin
      acc_nxt = acc_sum - `SSP_CLK_MHZ; // RL10
      tick_nxt = 1'b1;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= {`SSP_ACC_W{1'b0}};
      ref_tick <= 1'b0;
    end else if (ce) begin
      acc_r <= acc_nxt;
      ref_tick <= tick_nxt;
    end
  end

endmodule

/* File: include/ssp_regs.vh */
// Purpose: Constants for the serial and status pin control block.
// Assumes: Included by the design files by bare name.
// Notes: Definitions only.
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

// ****************************************
// Status output select codes
// ****************************************
`define SSP_SEL_OPERATE 2'h0
`define SSP_SEL_BUS_POWER 2'h1
`define SSP_SEL_BUS_ACTIVITY 2'h2
`define SSP_SEL_SOF 2'h3

// ****************************************
// I/O pin register layout
// ****************************************
`define SSP_IO_GPIN_MSB 7
`define SSP_IO_GPIN_LSB 4
`define SSP_IO_GPOUT_MSB 3
`define SSP_IO_GPOUT_LSB 0
`define SSP_IO_RESET 8'h00

// ****************************************
// Clocking and serial bit count
// ****************************************
// Rate constants are sized to the accumulator, so its arithmetic keeps a single width.
`define SSP_CLK_MHZ 9'h0FA
`define SSP_REF_MHZ 9'h00C
`define SSP_ACC_W 9
`define SSP_BIT_CNT_W 3
`define SSP_BIT_LAST 3'h7

`endif

/* File: sim/ssp_pin_props.sv */
// Purpose: Port-level checks of the serial and status pin control block.
// Assumes: ce is held high while the checks run.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
module ssp_pin_props #(parameter GPIN_W = 4) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Inputs
  input wire ss_n,
  input wire full_duplex,
  input wire status_select_high,
  input wire status_select_low,
  input wire interrupt_pin_enable,
  input wire int_level_mode,
  input wire int_pos_polarity,
  input wire operate,
  input wire bus_activity,
  input wire sof_pulse,
  input wire irq_pending,
  input wire [GPIN_W-1:0] general_input,
  // Outputs
  input wire miso_oe_n,
  input wire rx_valid,
  input wire multiplexed_status_output,
  input wire int_out,
  input wire int_oe_n,
  input wire bus_power_detect,
  input wire bus_power_on_event,
  input wire bus_power_off_event,
  input wire [7:0] io_rd_data
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire [3:0] src = {sof_pulse, bus_activity, bus_power_detect, operate};
  wire [1:0] sel = {status_select_high, status_select_low};
  chk_miso_float: assert property (
    (ss_n || !full_duplex) [*5] |-> miso_oe_n) else $error("data out driven");
  chk_status_mux: assert property (
    $past(rstn) |-> multiplexed_status_output == $past(src[sel])) else $error("status mux");
  chk_int_edge: assert property (
    $past(rstn && interrupt_pin_enable && !int_level_mode && irq_pending)
    |-> !int_oe_n && int_out == $past(int_pos_polarity)) else $error("edge interrupt");
  chk_int_level: assert property (
    $past(rstn && interrupt_pin_enable && int_level_mode)
    |-> int_oe_n == !$past(irq_pending)) else $error("level interrupt");
  chk_int_off: assert property (
    $past(rstn && !interrupt_pin_enable)
    |-> ($past(int_level_mode) ? int_oe_n : int_out == !$past(int_pos_polarity))) else $error("int off");
  chk_power_up: assert property (
    $rose(bus_power_detect) |-> bus_power_on_event) else $error("power on event");
  chk_power_down: assert property (
    $fell(bus_power_detect) |-> bus_power_off_event) else $error("power off event");
  chk_gpin_read: assert property (
    ($past(rstn, 4) && $stable(general_input)) [*5] |-> io_rd_data[7:4] == general_input)
    else $error("input readback");
  chk_rx_idle: assert property (
    ss_n [*8] |-> !rx_valid) else $error("byte while deselected");
  cover property (rx_valid);
  cover property (bus_power_off_event);
  cover property (!int_oe_n && int_level_mode);
endmodule
bind ssp_pin_ctrl ssp_pin_props #(.GPIN_W(GPIN_W)) u_props (
  .clk(clk),
  .rstn(rstn),
  .ss_n(ss_n),
  .full_duplex(full_duplex),
  .status_select_high(status_select_high),
  .status_select_low(status_select_low),
  .interrupt_pin_enable(interrupt_pin_enable),
  .int_level_mode(int_level_mode),
  .int_pos_polarity(int_pos_polarity),
  .operate(operate),
  .bus_activity(bus_activity),
  .sof_pulse(sof_pulse),
  .irq_pending(irq_pending),
  .general_input(general_input),
  .miso_oe_n(miso_oe_n),
  .rx_valid(rx_valid),
  .multiplexed_status_output(multiplexed_status_output),
  .int_out(int_out),
  .int_oe_n(int_oe_n),
  .bus_power_detect(bus_power_detect),
  .bus_power_on_event(bus_power_on_event),
  .bus_power_off_event(bus_power_off_event),
  .io_rd_data(io_rd_data)
);

/* File: sim/ssp_spi_master.sv */
// Purpose: Behavioural serial master on the far side of the block.
// Assumes: Mode (0,0); the serial clock stands still low between transfers.
// Notes: A released data line shows the inverse of its last value.
`timescale 1ns/1ps
module ssp_spi_master (
  // Link pins
  output reg sclk = 1'b0,
  output reg ss_n = 1'b1,
  output wire mosi_line,
  // Device side of the pins
  input wire mosi_out, mosi_oe_n, miso_out, miso_oe_n
);
  reg m_d = 1'b0;
  reg m_en = 1'b1;
  reg last_miso = 1'b0;
  wire miso_line = miso_oe_n ? ~last_miso : miso_out;
  assign mosi_line = !mosi_oe_n ? mosi_out : (m_en ? m_d : ~m_d);
  task sel(input on);
    ss_n = !on;
    #125;
  endtask
  // Read bytes release the shared line so the device can drive it.
  task xfer(input [7:0] d, input rd, output [7:0] q);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      m_en = !rd;
      m_d = d[i];
      #62.5 sclk = 1'b1;
      q[i] = rd ? mosi_line : miso_line;
      last_miso = miso_line;
      #62.5 sclk = 1'b0;
    end
  endtask
endmodule

/* File: sim/tb.sv */
// Purpose: Self-checking bench of the serial and status pin control block.
// Assumes: ce is held high; the serial link runs at 125 ns per bit.
// Notes: All waits are fixed by the latencies of the block.
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0, rstn = 1'b0, ce = 1'b1, full_duplex = 1'b1, hd_read_byte = 1'b0, io_wr = 1'b0;
  reg status_select_high = 1'b0, status_select_low = 1'b0, interrupt_pin_enable = 1'b0;
  reg int_level_mode = 1'b1, int_pos_polarity = 1'b0, irq_pending = 1'b0;
  reg operate = 1'b0, bus_activity = 1'b0, sof_pulse = 1'b0, bus_power_comparator_input = 1'b0;
  reg [7:0] tx_data = 8'h00, io_wr_data = 8'h00, q;
  reg [3:0] general_input = 4'hF;
  integer n_mismatch = 0, num_checks = 0, n_rx = 0, n_tx = 0, n_tick = 0, k;
  wire sclk, ss_n, mosi_in, mosi_out, mosi_oe_n, miso_out, miso_oe_n, rx_valid;
  wire multiplexed_status_output, int_out, int_oe_n, bus_power_detect;
  wire tx_next, selected, bus_power_on_event, bus_power_off_event, ref_tick;
  wire [3:0] general_output;
  wire [7:0] rx_byte, io_rd_data;
  ssp_pin_ctrl #(.GPIN_W(4)) DUT (.clk, .rstn, .ce, .sclk, .ss_n, .mosi_in, .mosi_out, .mosi_oe_n,
    .miso_out, .miso_oe_n, .tx_data, .hd_read_byte, .rx_byte, .rx_valid, .tx_next, .selected,
    .full_duplex, .status_select_high, .status_select_low, .interrupt_pin_enable, .int_level_mode,
    .int_pos_polarity, .operate, .bus_activity, .sof_pulse, .irq_pending, .multiplexed_status_output,
    .int_out, .int_oe_n, .bus_power_comparator_input, .bus_power_detect, .bus_power_on_event,
    .bus_power_off_event, .general_input, .io_wr, .io_wr_data, .io_rd_data, .general_output,
    .ref_tick);
  ssp_spi_master u_master (.sclk, .ss_n, .mosi_line(mosi_in), .mosi_out, .mosi_oe_n, .miso_out,
    .miso_oe_n);
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (rx_valid === 1'b1) n_rx <= n_rx + 1;
  always @(posedge clk) if (tx_next === 1'b1) n_tx <= n_tx + 1;
  always @(posedge clk) if (ref_tick === 1'b1) n_tick <= n_tick + 1;
  task step(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // A hang is cut short here and counted against the run.
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end
  initial begin
    step(12);
    rstn = 1'b1;
    step(2);
    // Selected source low and the others high, then the reverse.
    for (k = 0; k < 8; k = k + 1) begin
      {status_select_high, status_select_low} = k[1:0];
      {sof_pulse, bus_activity, bus_power_comparator_input, operate} = (4'h1 << k[1:0]) ^ {4{~k[2]}};
      step(8);
      chk(multiplexed_status_output, k[2]);
    end
    bus_power_comparator_input = 1'b1;
    step(3);
    chk({bus_power_detect, bus_power_on_event}, 8'h03);
    step(3);
    chk({bus_power_detect, bus_power_on_event}, 8'h02);
    bus_power_comparator_input = 1'b0;
    step(3);
    chk({bus_power_detect, bus_power_off_event}, 8'h01);
    step(3);
    chk({bus_power_detect, bus_power_off_event}, 8'h00);
    irq_pending = 1'b1;
    step(2);
    chk(int_oe_n, 1);
    interrupt_pin_enable = 1'b1;
    step(2);
    chk(int_oe_n, 0);
    int_level_mode = 1'b0;
    int_pos_polarity = 1'b1;
    step(2);
    chk({int_oe_n, int_out}, 8'h01);
    int_pos_polarity = 1'b0;
    irq_pending = 1'b0;
    step(2);
    chk({int_oe_n, int_out}, 8'h01);
    irq_pending = 1'b1;
    interrupt_pin_enable = 1'b0;
    step(2);
    chk({int_oe_n, int_out}, 8'h01);
    interrupt_pin_enable = 1'b1;
    step(2);
    chk({int_oe_n, int_out}, 8'h00);
    general_input = 4'hA;
    io_wr_data = 8'h53;
    io_wr = 1'b1;
    step(1);
    io_wr = 1'b0;
    step(5);
    chk(io_rd_data, 8'hA3);
    chk(general_output, 8'h03);
    tx_data = 8'hC5;
    u_master.sel(1);
    tx_data = 8'h6E;
    chk({selected, miso_oe_n, mosi_oe_n}, 8'h05);
    u_master.xfer(8'h3A, 1'b0, q);
    chk(q, 8'hC5);
    chk(rx_byte, 8'h3A);
    u_master.xfer(8'h81, 1'b0, q);
    chk(q, 8'h6E);
    chk(rx_byte, 8'h81);
    u_master.sel(0);
    chk({selected, miso_oe_n, mosi_oe_n}, 8'h03);
    full_duplex = 1'b0;
    hd_read_byte = 1'b1;
    tx_data = 8'h96;
    u_master.sel(1);
    chk({selected, miso_oe_n, mosi_oe_n}, 8'h06);
    u_master.xfer(8'h00, 1'b1, q);
    chk(q, 8'h96);
    u_master.sel(0);
    chk({selected, mosi_oe_n}, 8'h01);
    u_master.xfer(8'hFF, 1'b0, q);
    step(8);
    chk(n_rx == 3, 1);
    chk(n_tx == 3, 1);
    k = n_tick;
    step(250);
    chk(n_tick - k, 8'h0C);
    test_done;
  end
endmodule
